// File: rtl/powerfail_protection_controller.sv
`timescale 1ns/1ps
// Function
// - Answer only at select code five
// - Sixty-four backed bytes at registers 8-71
// - Clock and bytes survive shutdown
// - Powerfail timer zeroed, counts after failure
// - Power-failed event after programmed delay
// - Power off at protection time
// - Power-back timer zeroed, counts on return
// - Leave powerfail state after back delay
// - Overheat timer rises while failed
// - Overheat falls half rate, stops zero
// - Power off at sixty seconds overheat
// - Interrupt near one second remaining
// - Interrupt when power returns
// - Interrupt when failure detected
// - Mask one selects power-failed only
// - Cause register readable at register one
// - Mask seven enables all three
// - Cause bits sticky, cleared by read
// - Delays counted in hundredths of second
module powerfail_protection_controller
   import powerfail_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   // Host register port
   input  wire logic [7:0]  i_sel_code,
   input  wire logic [7:0]  i_reg_num,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [15:0] i_wdata,
   output logic      [15:0] o_rdata,
   output logic             o_rvalid,
   // Power sensing
   input  wire logic        i_ac_present,
   // System outputs
   output logic             o_irq,
   output logic             o_power_off,
   output logic             o_pfail_state,
   output logic [31:0]      o_rtc_seconds
);

   initial begin
      if (TICK_DIV < 1) begin
         $error("TICK_DIV must be at least one");
      end
   end

   typedef enum {ST_NORMAL, ST_PENDING, ST_FAILED, ST_RETURNING} pf_state_t;

   pf_state_t        state;
   logic [31:0]      tick_cnt;
   logic             tick;
   logic [6:0]       hund_cnt;
   logic [15:0]      pfail_timer;
   logic [15:0]      pback_timer;
   logic [15:0]      overheat;
   logic             half_rate;
   logic [15:0]      pback_delay;
   logic [15:0]      protection;
   logic [15:0]      pfail_delay;
   logic [7:0]       enable_mask;
   logic [EVENT_BITS-1:0] cause;
   logic [EVENT_BITS-1:0] event_set;
   logic             one_sec_done;
   logic [7:0]       mem [MEM_BYTES];
   logic             selected;
   logic             rd_cause;
   logic             ac_q;

   assign selected = (i_sel_code == SELECT_CODE);
   assign rd_cause = selected && i_rd && (i_reg_num == REG_CAUSE);

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b0;
      end else if (tick_cnt == 32'(TICK_DIV - 1)) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
         tick     <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         hund_cnt      <= 7'h00;
         o_rtc_seconds <= 32'h0000_0000;
      end else if (tick) begin
         if (hund_cnt == 7'(RTC_HUND_PER_SEC - 1)) begin
            hund_cnt      <= 7'h00;
            o_rtc_seconds <= o_rtc_seconds + 32'h0000_0001;
         end else begin
            hund_cnt <= hund_cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         ac_q <= 1'b1;
      end else begin
         ac_q <= i_ac_present;
      end
   end

   // Powerfail sequence
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state       <= ST_NORMAL;
         pfail_timer <= 16'h0000;
         pback_timer <= 16'h0000;
      end else begin
         case (state)
            ST_NORMAL: begin
               if (!ac_q) begin
                  pfail_timer <= 16'h0000;
                  state       <= ST_PENDING;
               end
            end
            ST_PENDING: begin
               if (ac_q) begin
                  state <= ST_NORMAL;
               end else if (tick) begin
                  pfail_timer <= pfail_timer + 16'h0001;
                  if (pfail_timer + 16'h0001 >= pfail_delay) begin
                     state <= ST_FAILED;
                  end
               end
            end
            ST_FAILED: begin
               if (ac_q) begin
                  pback_timer <= 16'h0000;
                  state       <= ST_RETURNING;
               end else if (tick) begin
                  pfail_timer <= pfail_timer + 16'h0001;
               end
            end
            ST_RETURNING: begin
               if (!ac_q) begin
                  state <= ST_FAILED;
               end else if (tick) begin
                  pback_timer <= pback_timer + 16'h0001;
                  if (pback_timer + 16'h0001 >= pback_delay) begin
                     state <= ST_NORMAL;
                  end
               end
            end
            default: begin
               state <= ST_NORMAL;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         overheat  <= 16'h0000;
         half_rate <= 1'b0;
      end else if (tick) begin
         if (!ac_q) begin
            half_rate <= 1'b0;
            if (overheat < OVERHEAT_LIMIT) begin
               overheat <= overheat + 16'h0001;
            end
         end else begin
            half_rate <= ~half_rate;
            if (half_rate && overheat != 16'h0000) begin
               overheat <= overheat - 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_power_off <= 1'b0;
      end else if (overheat >= OVERHEAT_LIMIT) begin
         o_power_off <= 1'b1;
      end else if ((state == ST_PENDING || state == ST_FAILED) && pfail_timer >= protection) begin
         o_power_off <= 1'b1;
      end else if (selected && i_wr && i_reg_num == 8'h00 && i_wdata != 16'h0000) begin
         o_power_off <= 1'b1;
      end
   end

   // Event detection
   always_comb begin
      event_set = '0;
      event_set[BIT_PFAIL] = (state == ST_PENDING) && tick && !ac_q &&
                             (pfail_timer + 16'h0001 >= pfail_delay);
      event_set[BIT_PBACK] = (state == ST_RETURNING) && tick && ac_q &&
                             (pback_timer + 16'h0001 >= pback_delay);
      event_set[BIT_ONE_SEC] = !one_sec_done && (state == ST_FAILED || state == ST_PENDING) &&
                               (pfail_timer + ONE_SEC_HUND >= protection);
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         one_sec_done <= 1'b0;
      end else if (state == ST_NORMAL) begin
         one_sec_done <= 1'b0;
      end else if (event_set[BIT_ONE_SEC]) begin
         one_sec_done <= 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cause <= '0;
      end else if (rd_cause) begin
         cause <= event_set;
      end else begin
         cause <= cause | event_set;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(cause & enable_mask[EVENT_BITS-1:0]);
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_pfail_state <= 1'b0;
      end else begin
         o_pfail_state <= (state == ST_FAILED) || (state == ST_RETURNING);
      end
   end

   // Control register writes
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         enable_mask <= RST_ENABLE_MASK;
         pback_delay <= RST_PBACK_DELAY;
         protection  <= RST_PROTECTION;
         pfail_delay <= RST_PFAIL_DELAY;
      end else if (selected && i_wr) begin
         case (i_reg_num)
            REG_ENABLE_MASK: enable_mask <= {5'h00, i_wdata[EVENT_BITS-1:0]};
            REG_PBACK_DELAY: pback_delay <= i_wdata;
            REG_PROTECTION:  protection  <= i_wdata;
            REG_PFAIL_DELAY: pfail_delay <= i_wdata;
            default: begin
            end
         endcase
      end
   end

   generate
      for (genvar g = 0; g < MEM_BYTES; g++) begin : g_mem
         always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
               mem[g] <= 8'h00;
            end else if (selected && i_wr && i_reg_num == REG_MEM_FIRST + 8'(g)) begin
               mem[g] <= i_wdata[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rdata  <= 16'h0000;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= selected && i_rd;
         if (selected && i_rd) begin
            if (i_reg_num >= REG_MEM_FIRST && i_reg_num <= REG_MEM_LAST) begin
               o_rdata <= {8'h00, mem[6'(i_reg_num - REG_MEM_FIRST)]};
            end else begin
               case (i_reg_num)
                  REG_CAUSE:       o_rdata <= {13'h0000, cause};
                  REG_ENABLE_MASK: o_rdata <= {8'h00, enable_mask};
                  8'h03:           o_rdata <= {14'h0000, ~ac_q, o_pfail_state};
                  8'h04:           o_rdata <= overheat;
                  REG_PBACK_DELAY: o_rdata <= pback_timer;
                  REG_PROTECTION:  o_rdata <= pfail_timer;
                  default:         o_rdata <= 16'h0000;
               endcase
            end
         end
      end
   end

endmodule : powerfail_protection_controller

// File: include/powerfail_pkg.sv
package powerfail_pkg;
   // Host register access
   localparam logic [7:0] SELECT_CODE      = 8'h05;
   localparam logic [7:0] REG_CAUSE        = 8'h01;
   localparam logic [7:0] REG_ENABLE_MASK  = 8'h02;
   localparam logic [7:0] REG_PBACK_DELAY  = 8'h05;
   localparam logic [7:0] REG_PROTECTION   = 8'h06;
   localparam logic [7:0] REG_PFAIL_DELAY  = 8'h07;
   localparam logic [7:0] REG_MEM_FIRST    = 8'h08;
   localparam logic [7:0] REG_MEM_LAST     = 8'h47;
   localparam int         MEM_BYTES        = 64;
   // Event bit positions
   localparam int         BIT_PFAIL        = 0;
   localparam int         BIT_PBACK        = 1;
   localparam int         BIT_ONE_SEC      = 2;
   localparam int         EVENT_BITS       = 3;
   // Reset values, delays in hundredths of a second
   localparam logic [15:0] RST_PBACK_DELAY = 16'h0032;
   localparam logic [15:0] RST_PROTECTION  = 16'h1770;
   localparam logic [15:0] RST_PFAIL_DELAY = 16'h000a;
   localparam logic [7:0]  RST_ENABLE_MASK = 8'h00;
   // Timing
   localparam int         CLK_HZ           = 100_000_000;
   localparam int         TICK_MS          = 10;
   localparam int         TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
   localparam logic [15:0] OVERHEAT_LIMIT  = 16'd6000;
   localparam logic [15:0] ONE_SEC_HUND    = 16'd100;
   localparam int         RTC_HUND_PER_SEC = 100;
endpackage : powerfail_pkg

// File: sim/powerfail_protection_controller_checker.sv
`timescale 1ns/1ps
module powerfail_protection_controller_checker
   import powerfail_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   // Watched ports
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   input wire logic [7:0]  i_sel_code,
   input wire logic [7:0]  i_reg_num,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] i_wdata,
   input wire logic [15:0] o_rdata,
   input wire logic        o_rvalid,
   input wire logic        i_ac_present,
   input wire logic        o_irq,
   input wire logic        o_power_off,
   input wire logic        o_pfail_state,
   input wire logic [31:0] o_rtc_seconds
);
   logic [2:0] mask_seen;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence host_read;
      i_rd && i_sel_code == SELECT_CODE;
   endsequence
   sequence mem_read;
      host_read and (i_reg_num >= REG_MEM_FIRST && i_reg_num <= REG_MEM_LAST);
   endsequence
   sequence cause_read;
      host_read and (i_reg_num == REG_CAUSE);
   endsequence
   // Low mask bits as last written
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mask_seen <= 3'h0;
      end else if (i_wr && i_sel_code == SELECT_CODE && i_reg_num == REG_ENABLE_MASK) begin
         mask_seen <= i_wdata[2:0];
      end
   end
   a_read_answered: assert property (host_read |=> o_rvalid)
      else $error("read at own select code not answered");
   a_foreign_quiet: assert property (!(i_rd && i_sel_code == SELECT_CODE) |=> !o_rvalid)
      else $error("answer without own read");
   a_mem_byte_wide: assert property (mem_read |=> o_rdata[15:8] == 8'h00)
      else $error("memory byte wider than 8 bits");
   a_cause_upper_zero: assert property (cause_read |=> o_rdata[15:3] == 13'h0000)
      else $error("unused cause bits set");
   a_power_off_holds: assert property (o_power_off |=> o_power_off)
      else $error("power off dropped");
   a_rtc_one_step: assert property ($changed(o_rtc_seconds) |-> o_rtc_seconds == $past(o_rtc_seconds) + 32'h1)
      else $error("clock jumped");
   a_fail_needs_ac: assert property ($rose(o_pfail_state) |-> !$past(i_ac_present) || !$past(i_ac_present, 2))
      else $error("failed state with mains present");
   a_irq_masked_off: assert property (mask_seen == 3'h0 && $past(mask_seen) == 3'h0 && $past(mask_seen, 2) == 3'h0 |-> !o_irq)
      else $error("interrupt with empty mask");
endmodule : powerfail_protection_controller_checker
bind powerfail_protection_controller powerfail_protection_controller_checker #(.TICK_DIV(TICK_DIV)) u_checker (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sel_code(i_sel_code), .i_reg_num(i_reg_num), .i_wr(i_wr),
   .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_ac_present(i_ac_present),
   .o_irq(o_irq), .o_power_off(o_power_off), .o_pfail_state(o_pfail_state), .o_rtc_seconds(o_rtc_seconds));

// File: sim/host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model (
   // Clock
   input  wire logic        i_clk_sys,
   // Register port toward the controller
   output logic      [7:0]  o_sel_code,
   output logic      [7:0]  o_reg_num,
   output logic             o_wr,
   output logic             o_rd,
   output logic      [15:0] o_wdata,
   input  wire logic [15:0] i_rdata,
   input  wire logic        i_rvalid
);
   initial begin
      o_sel_code = 8'h00;
      o_reg_num  = 8'h00;
      o_wr       = 1'b0;
      o_rd       = 1'b0;
      o_wdata    = 16'h0000;
   end
   task automatic wr(input logic [7:0] sel, input logic [7:0] num, input logic [15:0] dat);
      @(posedge i_clk_sys);
      o_sel_code <= sel;
      o_reg_num  <= num;
      o_wdata    <= dat;
      o_wr       <= 1'b1;
      @(posedge i_clk_sys);
      o_wr       <= 1'b0;
      o_wdata    <= ~dat;
   endtask : wr
   // Data sampled once answer has settled
   task automatic rd(input logic [7:0] sel, input logic [7:0] num, output logic [15:0] dat, output logic ok);
      @(posedge i_clk_sys);
      o_sel_code <= sel;
      o_reg_num  <= num;
      o_rd       <= 1'b1;
      @(posedge i_clk_sys);
      o_rd       <= 1'b0;
      o_reg_num  <= ~num;
      #1;
      ok  = i_rvalid;
      dat = i_rdata;
   endtask : rd
endmodule : host_cpu_model

// File: sim/powerfail_protection_controller_test.sv
`timescale 1ns/1ps
module powerfail_protection_controller_test import powerfail_pkg::*;;
   localparam int TDIV = 4;
   logic        i_clk_sys, i_rst, i_wr, i_rd, o_rvalid, i_ac_present, o_irq, o_power_off, o_pfail_state, ok;
   logic [7:0]  i_sel_code, i_reg_num;
   logic [15:0] i_wdata, o_rdata, d, t;
   logic [31:0] o_rtc_seconds;
   int          num_errors, compares, n, mem_model[64];
   int          masks[3] = '{1, 7, 255};
   powerfail_protection_controller #(.TICK_DIV(TDIV)) u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_sel_code(i_sel_code), .i_reg_num(i_reg_num), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
      .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_ac_present(i_ac_present), .o_irq(o_irq),
      .o_power_off(o_power_off), .o_pfail_state(o_pfail_state), .o_rtc_seconds(o_rtc_seconds));
   host_cpu_model u_host (.i_clk_sys(i_clk_sys), .o_sel_code(i_sel_code), .o_reg_num(i_reg_num), .o_wr(i_wr),
      .o_rd(i_rd), .o_wdata(i_wdata), .i_rdata(o_rdata), .i_rvalid(o_rvalid));
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic rdchk(input logic [7:0] num, input logic [15:0] exp);
      u_host.rd(SELECT_CODE, num, d, ok);
      check({15'h0, ok, d}, {15'h0, 1'b1, exp});
   endtask : rdchk
   task automatic wait_hi(input int which, input int lim, output int cyc);
      cyc = 0;
      while (((which == 0) ? o_irq : o_power_off) !== 1'b1 && cyc < lim) begin
         @(posedge i_clk_sys);
         cyc++;
      end
   endtask : wait_hi
   task automatic mains(input logic up);
      @(posedge i_clk_sys);
      i_ac_present <= up;
   endtask : mains
   task automatic complete_run;
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      #400000;
      num_errors++;
      complete_run();
   end
   initial begin
      n = $urandom(32'he1f980be);
      i_ac_present = 1'b1;
      i_rst = 1'b1;
      repeat (6) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rdchk(REG_ENABLE_MASK, RST_ENABLE_MASK);
      u_host.wr(8'h03, REG_MEM_FIRST, 16'h00a5);
      u_host.rd(8'h03, REG_MEM_FIRST, d, ok);
      check(ok, 1'b0);
      for (n = 0; n < MEM_BYTES; n++) begin
         mem_model[n] = $urandom & 32'hff;
         u_host.wr(SELECT_CODE, REG_MEM_FIRST + n[7:0], mem_model[n][15:0]);
      end
      for (n = 0; n < MEM_BYTES; n++) rdchk(REG_MEM_FIRST + n[7:0], mem_model[n][15:0]);
      foreach (masks[i]) begin
         u_host.wr(SELECT_CODE, REG_ENABLE_MASK, masks[i][15:0]);
         rdchk(REG_ENABLE_MASK, masks[i][15:0] & 16'h0007);
      end
      $display("register test done");
      mains(1'b0);
      repeat (3 * TDIV) @(posedge i_clk_sys);
      mains(1'b1);
      repeat (100) @(posedge i_clk_sys);
      rdchk(REG_CAUSE, 16'h0000);
      $display("short outage test done");
      mains(1'b0);
      wait_hi(0, 400, n);
      check(n >= 9 * TDIV && n <= 10 * TDIV + 12, 1'b1);
      check(o_pfail_state, 1'b1);
      rdchk(REG_CAUSE, 16'h0001);
      rdchk(REG_CAUSE, 16'h0000);
      check(o_irq, 1'b0);
      u_host.rd(SELECT_CODE, 8'h06, t, ok);
      repeat (8 * TDIV) @(posedge i_clk_sys);
      u_host.rd(SELECT_CODE, 8'h06, d, ok);
      check(ok, 1'b1);
      check(d - t >= 16'd8 && d - t <= 16'd9, 1'b1);
      u_host.rd(SELECT_CODE, 8'h04, d, ok);
      check(d != 16'h0000, 1'b1);
      $display("failure test done");
      mains(1'b1);
      u_host.rd(SELECT_CODE, 8'h04, t, ok);
      repeat (8 * TDIV) @(posedge i_clk_sys);
      u_host.rd(SELECT_CODE, 8'h04, d, ok);
      check(t - d >= 16'd3 && t - d <= 16'd5, 1'b1);
      wait_hi(0, 400, n);
      check(n >= 37 * TDIV && n <= 45 * TDIV, 1'b1);
      rdchk(REG_CAUSE, 16'h0002);
      check(o_pfail_state, 1'b0);
      repeat (200) @(posedge i_clk_sys);
      rdchk(8'h04, 16'h0000);
      $display("power back test done");
      u_host.wr(SELECT_CODE, REG_PROTECTION, 16'd150);
      mains(1'b0);
      wait_hi(1, 1000, n);
      check(n >= 149 * TDIV && n <= 150 * TDIV + 12, 1'b1);
      rdchk(REG_CAUSE, 16'h0005);
      rdchk(REG_MEM_FIRST, mem_model[0][15:0]);
      $display("protection test done");
      @(negedge i_clk_sys);
      n = o_rtc_seconds;
      repeat (100 * TDIV) @(negedge i_clk_sys);
      check(o_rtc_seconds - n, 32'h1);
      $display("clock test done");
      complete_run();
   end
endmodule : powerfail_protection_controller_test
